/* hw/rtx_pkg.sv */
// Package for the rotate and program-memory table access execution block
package rtx_pkg;
  // Opcode fields: upper byte of the 16-bit instruction word
  localparam logic [6:0] RTX_OPC_ROTATE = 7'h0C;  // 0001 100d
  localparam logic [5:0] RTX_OPC_TWRITE = 6'h2B;  // 1010 11ti
  localparam logic [5:0] RTX_OPC_TREAD  = 6'h2A;  // 1010 10ti
  localparam int RTX_BIT_DEST = 8;
  localparam int RTX_BIT_INC  = 8;
  localparam int RTX_BIT_HIGH = 9;
  // Quarter-cycle phase codes (Q1..Q4)
  localparam logic [1:0] RTX_Q1 = 2'h0;
  localparam logic [1:0] RTX_Q2 = 2'h1;
  localparam logic [1:0] RTX_Q3 = 2'h2;
  localparam logic [1:0] RTX_Q4 = 2'h3;
  localparam logic [15:0] RTX_PTR_RST   = 16'h0000;
  localparam logic [15:0] RTX_LATCH_RST = 16'h0000;
  // Progress marks kept in the scratch byte of the table instructions
  localparam logic [7:0] RTX_STP_START  = 8'h00;  // Nothing done yet
  localparam logic [7:0] RTX_STP_LOADED = 8'h01;  // Latch byte taken
  localparam logic [7:0] RTX_STP_SECOND = 8'h02;  // Second cycle running
  localparam logic [7:0] RTX_STP_WAIT   = 8'h03;  // Internal write pending

  typedef enum logic [2:0] {
    RTX_IDLE   = 3'b000,
    RTX_ROT    = 3'b001,
    RTX_WR_EXT = 3'b010,
    RTX_WR_INT = 3'b011,
    RTX_RD     = 3'b100
  } rtx_state_t;

  // Program memory request group
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        abort;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rtx_pm_req_t;

  // Register file write request group
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } rtx_rf_wr_t;

  typedef struct packed {
    rtx_state_t  state;
    logic [1:0]  q;
    logic [15:0] ir;
    logic [7:0]  opnd;
    logic [7:0]  result;
    logic        carry;
    logic [7:0]  working_register;
    logic        working_register_we;
    logic [15:0] ptr;
    logic [15:0] latch;
    rtx_pm_req_t pm;
    rtx_rf_wr_t  rf;
    logic        busy;
    logic        done;
  } rtx_regs_t;
endpackage : rtx_pkg

/* hw/rtx_exec.sv */
// Execution unit: rotate right via carry and program-memory table access
`timescale 1ns/100ps
module rtx_exec
  import rtx_pkg::*;
#(
  parameter int PTR_W = 16
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        issue_i,       // Start instruction, at Q1
  input  wire logic [15:0] instr_i,
  input  wire logic [7:0]  rf_rdata_i,    // File register read data
  input  wire logic        carry_i,
  input  wire logic        irq_i,         // Interrupt request
  input  wire logic        ext_target_i,  // Pointer hits external memory
  input  wire logic        pm_done_i,     // Internal write finished
  input  wire logic [15:0] pm_rdata_i,
  output logic [7:0]       rf_raddr_o,
  output rtx_rf_wr_t       rf_wr_o,
  output logic [7:0]       working_register_o,
  output logic             working_register_we_o,
  output logic             carry_o,
  output rtx_pm_req_t      pm_req_o,
  output logic [15:0]      ptr_o,
  output logic [15:0]      latch_o,
  output logic             busy_o,
  output logic             done_o
);

  rtx_regs_t s_reg;
  rtx_regs_t s_next;

  logic is_rot;
  logic is_twr;
  logic is_trd;
  logic dflag;
  logic hsel;

  // Decode of the held instruction
  assign is_rot = (s_reg.ir[15:9] == RTX_OPC_ROTATE);
  assign is_twr = (s_reg.ir[15:10] == RTX_OPC_TWRITE);
  assign is_trd = (s_reg.ir[15:10] == RTX_OPC_TREAD);
  assign dflag  = s_reg.ir[RTX_BIT_DEST];
  assign hsel   = s_reg.ir[RTX_BIT_HIGH];

  // Next-state logic; every instruction steps through Q1..Q4 phases
  always_comb begin
    s_next         = s_reg;
    s_next.pm.wr   = 1'b0;
    s_next.pm.rd   = 1'b0;
    s_next.pm.abort = 1'b0;
    s_next.rf.we   = 1'b0;
    s_next.working_register_we = 1'b0;
    s_next.done    = 1'b0;
    s_next.q       = s_reg.q + 2'h1;
    case (s_reg.state)
      RTX_IDLE: begin
        s_next.q = RTX_Q1;
        if (issue_i) begin
          s_next.ir   = instr_i;
          s_next.busy = 1'b1;
          s_next.q    = RTX_Q2;
          // A rotate leaves its result here; table steps must start clean
          s_next.result = RTX_STP_START;
          if (instr_i[15:9] == RTX_OPC_ROTATE) begin
            s_next.state = RTX_ROT;
          end else if (instr_i[15:10] == RTX_OPC_TWRITE) begin
            s_next.state = ext_target_i ? RTX_WR_EXT : RTX_WR_INT;
          end else if (instr_i[15:10] == RTX_OPC_TREAD) begin
            s_next.state = RTX_RD;
          end else begin
            s_next.busy = 1'b0;
            s_next.q    = RTX_Q1;
          end
        end
      end
      RTX_ROT: begin
        case (s_reg.q)
          RTX_Q2: s_next.opnd = rf_rdata_i;
          RTX_Q3: begin
            s_next.result = {carry_i, s_reg.opnd[7:1]};
            s_next.carry  = s_reg.opnd[0];
          end
          default: begin
            // Q4 write-back, only carry flag touched besides result
            if (dflag) begin
              s_next.rf.we   = 1'b1;
              s_next.rf.addr = s_reg.ir[7:0];
              s_next.rf.data = s_reg.result;
            end else begin
              s_next.working_register    = s_reg.result;
              s_next.working_register_we = 1'b1;
            end
            s_next.state = RTX_IDLE;
            s_next.busy  = 1'b0;
            s_next.done  = 1'b1;
            s_next.q     = RTX_Q1;
          end
        endcase
      end
      RTX_WR_EXT, RTX_WR_INT: begin
        if (s_reg.q == RTX_Q2 && s_reg.result == RTX_STP_START) begin
          s_next.result = RTX_STP_LOADED;
          if (hsel) s_next.latch[15:8] = rf_rdata_i;
          else      s_next.latch[7:0]  = rf_rdata_i;
        end else if (s_reg.q == RTX_Q4
                     && s_reg.result == RTX_STP_LOADED) begin
          // First cycle over; the memory access owns the second one
          s_next.result = RTX_STP_SECOND;
        end else if (s_reg.q == RTX_Q4
                     && s_reg.result == RTX_STP_SECOND) begin
          // Second cycle: launch memory write of the whole latch
          s_next.result   = RTX_STP_WAIT;
          s_next.pm.wr    = 1'b1;
          s_next.pm.addr  = s_reg.ptr;
          s_next.pm.wdata = s_reg.latch;
          if (s_reg.state == RTX_WR_EXT) begin
            s_next.state = RTX_IDLE;
          end
        end else if (s_reg.state == RTX_WR_INT
                     && s_reg.result == RTX_STP_WAIT) begin
          // The finish pulse may land in any phase, so it is taken at
          // once; the interrupt is a level and is honoured at Q4 only
          if (pm_done_i) begin
            s_next.state = RTX_IDLE;
          end else if (irq_i && s_reg.q == RTX_Q4) begin
            s_next.pm.abort = 1'b1;
            s_next.state    = RTX_IDLE;
          end
        end
        if (s_next.state == RTX_IDLE) begin
          if (s_reg.ir[RTX_BIT_INC]) begin
            s_next.ptr = s_reg.ptr + 16'h0001;
          end
          s_next.busy   = 1'b0;
          s_next.done   = 1'b1;
          s_next.result = RTX_STP_START;
          s_next.q      = RTX_Q1;
        end
      end
      RTX_RD: begin
        if (s_reg.q == RTX_Q4 && s_reg.result == RTX_STP_START) begin
          // First cycle: old latch byte to register, fetch new word
          s_next.rf.we   = 1'b1;
          s_next.rf.addr = s_reg.ir[7:0];
          s_next.rf.data = hsel ? s_reg.latch[15:8]
                                : s_reg.latch[7:0];
          s_next.pm.rd   = 1'b1;
          s_next.pm.addr = s_reg.ptr;
          s_next.result  = RTX_STP_LOADED;
        end else if (s_reg.q == RTX_Q4
                     && s_reg.result == RTX_STP_LOADED) begin
          s_next.latch = pm_rdata_i;
          if (s_reg.ir[RTX_BIT_INC]) begin
            s_next.ptr = s_reg.ptr + 16'h0001;
          end
          s_next.state  = RTX_IDLE;
          s_next.busy   = 1'b0;
          s_next.done   = 1'b1;
          s_next.result = RTX_STP_START;
          s_next.q      = RTX_Q1;
        end
      end
      default: s_next.state = RTX_IDLE;
    endcase
  end

  // State register; constants only under reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg       <= '0;
      s_reg.state <= RTX_IDLE;
      s_reg.ptr   <= RTX_PTR_RST;
      s_reg.latch <= RTX_LATCH_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Read address follows a newly taken word, else the held one; an issue
  // refused while busy must not disturb the operand fetch under way
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) rf_raddr_o <= 8'h00;
    else       rf_raddr_o <= (issue_i && s_reg.state == RTX_IDLE)
                             ? instr_i[7:0] : s_reg.ir[7:0];
  end

  // Outputs straight from the state register
  assign rf_wr_o   = s_reg.rf;
  assign working_register_o    = s_reg.working_register;
  assign working_register_we_o = s_reg.working_register_we;
  assign carry_o   = s_reg.carry;
  assign pm_req_o  = s_reg.pm;
  assign ptr_o     = s_reg.ptr;
  assign latch_o   = s_reg.latch;
  assign busy_o    = s_reg.busy;
  assign done_o    = s_reg.done;

  // Checks
  a_rot_carry: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_reg.state == RTX_ROT && s_reg.q == RTX_Q3
    |=> carry_o == $past(s_reg.opnd[0]))
    else $error("rotate carry wrong");
  a_rot_dest: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rf_wr_o.we && is_rot |-> dflag)
    else $error("rotate wrote file with d=0");
  a_ext_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(busy_o) && s_reg.state == RTX_WR_EXT |-> ##7 done_o)
    else $error("external write too long");
  a_int_abort: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pm_req_o.abort |-> done_o && !busy_o)
    else $error("abort without end");
  a_ptr_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    done_o && !s_reg.ir[RTX_BIT_INC] |-> $stable(ptr_o))
    else $error("pointer moved with i=0");
  a_wr_data: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pm_req_o.wr |-> pm_req_o.wdata == latch_o)
    else $error("write data not latch");
  c_rot: cover property (@(posedge core_clk_i) is_rot && done_o);
  c_abort: cover property (@(posedge core_clk_i) pm_req_o.abort);
  c_read: cover property (@(posedge core_clk_i) is_trd && done_o);
  c_write: cover property (@(posedge core_clk_i) is_twr && done_o);
endmodule : rtx_exec

/* test/rtx_pmem_model.sv */
// Program memory model: fast external words, slow internal words
`timescale 1ns/100ps
module rtx_pmem_model
  import rtx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire rtx_pm_req_t req_i,
  input  wire logic        ext_i,
  input  wire logic [7:0]  dly_i,
  output logic             done_o,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [256];
  logic [15:0] waddr, wdata, raddr;
  logic [7:0]  cnt;
  logic [3:0]  rcnt;
  logic        tog;
  // Word stands 8 cycles; afterwards it flips each cycle so stale use shows
  assign rdata_o = mem[raddr[7:0]] ^ {16{tog & (rcnt == 4'h0)}};
  initial begin
    for (int k = 0; k < 256; k++) begin
      mem[k] = {k[7:0], ~k[7:0]};
    end
  end
  // Internal write commits on its own timer unless aborted first
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt    <= 8'h00;
      rcnt   <= 4'h0;
      tog    <= 1'b0;
      raddr  <= 16'h0000;
      done_o <= 1'b0;
    end else begin
      tog    <= ~tog;
      done_o <= 1'b0;
      if (rcnt != 4'h0) rcnt <= rcnt - 4'h1;
      if (req_i.rd) begin
        raddr <= req_i.addr;
        rcnt  <= 4'h8;
      end
      if (req_i.wr && ext_i) mem[req_i.addr[7:0]] <= req_i.wdata;
      else if (req_i.wr) begin
        cnt   <= dly_i;
        waddr <= req_i.addr;
        wdata <= req_i.wdata;
      end else if (req_i.abort) cnt <= 8'h00;
      else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01) begin
          mem[waddr[7:0]] <= wdata;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule : rtx_pmem_model

/* test/tb_rotate_and_table_access_exec.sv */
// Self-checking bench for the rotate and table access unit
`timescale 1ns/100ps
module tb_rotate_and_table_access_exec;
  import rtx_pkg::*;
  typedef struct packed {
    logic rf; logic wr; logic cc; logic c; logic [7:0] a; logic [7:0] val;
  } rtx_note_t;
  logic        clk;
  logic        rst   = 1'b1;
  logic        issue = 1'b0;
  logic [15:0] ins   = 16'h0000;
  logic [7:0]  rd    = 8'h00;
  logic        cin   = 1'b0;
  logic        irq   = 1'b0;
  logic        ext   = 1'b0;
  logic [7:0]  dly   = 8'h05;
  logic        pdone, wwe, cout, busy, done;
  logic [15:0] prd, ptr, lat, el, ep;
  logic [7:0]  raddr, working_register, va, vb, vc;
  rtx_rf_wr_t  rfw;
  rtx_pm_req_t pmr;
  rtx_note_t   notes[$];
  rtx_note_t   nt;
  logic        seen_we = 1'b0;
  logic [7:0]  seen_a  = 8'h00;
  logic [7:0]  seen_d  = 8'h00;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          seed = 32'h26a8;
  int          n;
  rtx_exec dut (.core_clk_i(clk), .rst_i(rst), .issue_i(issue),
    .instr_i(ins), .rf_rdata_i(rd), .carry_i(cin), .irq_i(irq),
    .ext_target_i(ext), .pm_done_i(pdone), .pm_rdata_i(prd),
    .rf_raddr_o(raddr), .rf_wr_o(rfw), .working_register_o(working_register), .working_register_we_o(wwe),
    .carry_o(cout), .pm_req_o(pmr), .ptr_o(ptr), .latch_o(lat),
    .busy_o(busy), .done_o(done));
  rtx_pmem_model pmem (.clk_i(clk), .rst_i(rst), .req_i(pmr), .ext_i(ext),
    .dly_i(dly), .done_o(pdone), .rdata_o(prd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // One instruction: issue, hold operands, wait for completion
  task automatic run(input logic [15:0] i, input logic [7:0] v,
                     input logic c, e);
    @(posedge clk);
    ins <= i;
    rd <= v;
    cin <= c;
    ext <= e;
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
      if (n == 2) check("busy_run", busy, 1'b1);
    end
    check("done_wait", n < 300, 1'b1);
    check("busy_end", busy, 1'b0);
    check("rf_raddr", raddr, {8'h00, i[7:0]});
    @(posedge clk);
  endtask : run
  task automatic pl();
    @(posedge clk);
    check("latch", lat, el);
    check("ptr", ptr, ep);
  endtask : pl
  task automatic tw(input logic t, i, e, input logic [7:0] v);
    el = t ? {v, el[7:0]} : {el[15:8], v};
    notes.push_back('{1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00});
    run({RTX_OPC_TWRITE, t, i, 8'h11}, v, 1'b0, e);
    // Issue edge plus two instruction cycles of four phases each
    if (e) check("ext_cycles", n, 16'h0009);
    ep = ep + {15'h0000, i};
    pl();
  endtask : tw
  task automatic tr(input logic t, i, input logic [15:0] w);
    notes.push_back('{1'b1, 1'b0, 1'b0, 1'b0, 8'h22, t ? el[15:8] : el[7:0]});
    run({RTX_OPC_TREAD, t, i, 8'h22}, 8'h00, 1'b0, 1'b0);
    el = w;
    ep = ep + {15'h0000, i};
    pl();
  endtask : tr
  // A table read writes the file four clocks before it completes, so file
  // writes are caught as they appear and judged at completion
  always @(posedge clk) begin
    if (!rst && rfw.we === 1'b1) begin
      seen_we = 1'b1;
      seen_a  = rfw.addr;
      seen_d  = rfw.data;
    end
    if (!rst && done === 1'b1) begin
      if (notes.size() == 0) check("extra_done", 1'b1, 1'b0);
      else begin
        nt = notes.pop_front();
        check("rf_we", seen_we, nt.rf);
        check("working_register_we", wwe, nt.wr);
        if (nt.rf) check("rf_addr", seen_a, nt.a);
        if (nt.rf) check("rf_data", seen_d, nt.val);
        if (nt.wr) check("working_register", working_register, nt.val);
        if (nt.cc) check("carry", cout, nt.c);
      end
      seen_we = 1'b0;
    end
  end
  // Hang guard well above the expected few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    el = 16'h0000;
    ep = 16'h0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      va = $random(seed);
      vb = $random(seed);
      vc = $random(seed);
      notes.push_back('{k[0], !k[0], 1'b1, va[0], vb, {vc[0], va[7:1]}});
      run({RTX_OPC_ROTATE, k[0], vb}, va, vc[0], 1'b0);
    end
    va = $random(seed);
    vb = $random(seed);
    vc = $random(seed);
    tw(1'b1, 1'b0, 1'b1, va);
    tw(1'b0, 1'b0, 1'b1, vb);
    tr(1'b1, 1'b0, {va, vb});
    dly <= 8'h3C;
    // Interrupt arrives long before the slow internal write finishes
    fork
      tw(1'b1, 1'b0, 1'b0, vc);
      begin
        repeat (10) @(posedge clk);
        irq <= 1'b1;
      end
    join
    check("abort_cycles", n < 40, 1'b1);
    irq <= 1'b0;
    dly <= 8'h05;
    repeat (70) @(posedge clk);
    tr(1'b1, 1'b1, {va, vb});
    tw(1'b0, 1'b1, 1'b0, vc);
    tr(1'b0, 1'b0, 16'h02FD);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule : tb_rotate_and_table_access_exec
